// ===== hdl/mode_bank_pkg.sv
package mode_bank_pkg;

    // Incoming 16-bit control word.
    typedef struct packed {
        logic read_not_write;
        logic [6:0] index;
        logic [7:0] data;
    } ctrl_word_t;

    typedef struct packed {
        logic atten_load_enable;
        logic [2:0] audio_format_sel;
        logic [1:0] deemph_rate_sel;
        logic deemph_enable;
        logic soft_mute_enable;
    } fmt_ctrl_t;

    typedef struct packed {
        logic output_phase_invert;
        logic [1:0] atten_step_rate;
        logic converter_operation_off;
        logic zero_flag_pin_function;
        logic bypass_stereo_sel;
        logic rolloff_sel;
        logic infinite_zero_mute_enable;
    } out_ctrl_t;

    typedef struct packed {
        logic reserved_bit;
        logic software_system_reset;
        logic one_bit_stream_mode;
        logic filter_bypass_sel;
        logic monaural_sel;
        logic monaural_channel_sel;
        logic [1:0] oversample_rate_sel;
    } if_ctrl_t;

    typedef struct packed {
        logic [4:0] reserved_bit;
        logic [1:0] stream_zero_output_enable;
        logic multibit_zero_output_enable;
    } zero_ctrl_t;

    // Settings that steer the audio path.
    typedef struct packed {
        fmt_ctrl_t fmt;
        out_ctrl_t outc;
        if_ctrl_t ifc;
        zero_ctrl_t zero;
    } mode_cfg_t;

    localparam logic [6:0] IDX_LEFT_ATTEN = 7'h10;
    localparam logic [6:0] IDX_RIGHT_ATTEN = 7'h11;
    localparam logic [6:0] IDX_FMT_CTRL = 7'h12;
    localparam logic [6:0] IDX_OUT_CTRL = 7'h13;
    localparam logic [6:0] IDX_IF_CTRL = 7'h14;
    localparam logic [6:0] IDX_ZERO_CTRL = 7'h15;
    localparam logic [6:0] IDX_ZERO_STATUS = 7'h16;
    localparam logic [6:0] IDX_LINK_ID = 7'h17;

    localparam logic [7:0] RST_ATTEN = 8'hFF;
    localparam logic [7:0] RST_FMT_CTRL = 8'h50;
    localparam logic [7:0] RST_OUT_CTRL = 8'h00;
    localparam logic [7:0] RST_IF_CTRL = 8'h00;
    localparam logic [7:0] RST_ZERO_CTRL = 8'h01;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Codes at or below this level give infinite attenuation.
    localparam logic [7:0] ATTEN_MUTE_MAX = 8'h0E;
    localparam logic [7:0] RAMP_FULL_MUTE = 8'h00;
    localparam logic [7:0] RAMP_NO_MUTE = 8'hFF;

endpackage : mode_bank_pkg

// ===== hdl/mode_register_bank.sv
// Notes on behaviour
// R1 - Word bit 15 high reads, low writes.
// R2 - Registers 22 and 23 are read-only.
// R3 - Bits 14:8 index 16..23, 7:0 data.
// R4 - Left/right 8-bit attenuation, default 0 dB.
// R5 - Load enable defaults off, multibit mode only.
// R6 - Format field defaults to 24-bit I2S.
// R7 - De-emphasis rate and enable default disabled.
// R8 - Soft mute defaults off, multibit only.
// R9 - Phase invert defaults normal, all modes.
// R10 - Step rate 1,2,4,8 sample periods.
// R11 - Converter operation defaults enabled.
// R12 - Zero pin function defaults data input.
// R13 - Bypass stereo select defaults monaural.
// R14 - Rolloff defaults sharp, multibit mode.
// R15 - Infinite zero mute defaults disabled.
// R16 - Software reset bit restores all defaults.
// R17 - One-bit stream mode defaults disabled.
// R18 - Filter bypass defaults internal filter.
// R19 - Monaural_sel defaults stereo, channel defaults left.
// R20 - Oversampling field defaults to 64 times.
// R21 - Zero-output enables: multibit on, stream off.
// R22 - Register 22 shows left/right zero flags.
// R23 - Register 23 shows 5-bit link number.
// R24 - Codes 14 and below mean infinite attenuation.
// R25 - Without load enable, applied levels hold.
// R26 - Soft mute ramps 255 steps at step rate.
// R27 - Reserved bits read zero, RO writes ignored.
`timescale 1ns/1ns
`default_nettype none

module mode_register_bank (
    input wire logic I_CORE_CLK,
    input wire logic I_NRST,
    input wire logic i_CE,
    input wire logic i_WORD_VALID,
    input wire mode_bank_pkg::ctrl_word_t i_WORD,
    input wire logic i_SAMPLE_TICK,
    input wire logic [1:0] i_ZERO_DETECT,
    input wire logic [4:0] i_LINK_DEVICE_NUMBER,
    output logic [7:0] o_RD_DATA,
    output logic o_RD_VALID,
    output mode_bank_pkg::mode_cfg_t o_CONFIG,
    output logic o_SOFT_RESET,
    output logic [7:0] o_LEFT_LEVEL,
    output logic [7:0] o_RIGHT_LEVEL,
    output logic o_LEFT_INF_ATTEN,
    output logic o_RIGHT_INF_ATTEN
);
    import mode_bank_pkg::*;

    typedef struct packed {
        logic [7:0] left_atten_level;
        logic [7:0] right_atten_level;
        mode_cfg_t cfg;
        logic [7:0] left_applied;
        logic [7:0] right_applied;
        logic [7:0] ramp;
        logic [2:0] step_cnt;
        logic [1:0] zero_flags;
        logic [4:0] link_device_number;
        logic [7:0] rd_data;
        logic rd_valid;
        logic soft_reset;
        logic [7:0] left_level;
        logic [7:0] right_level;
        logic left_inf;
        logic right_inf;
    } state_t;

    state_t state_reg;
    state_t state_next;

    ////////////////////////////////////////////////////////////////////////
    // Default state, shared by hard reset and the software reset bit.

    function automatic state_t reset_state();
        state_t s;
        s = '0;
        // R4 attenuation defaults
        s.left_atten_level = RST_ATTEN;
        s.right_atten_level = RST_ATTEN;
        s.left_applied = RST_ATTEN;
        s.right_applied = RST_ATTEN;
        // R5 R6 R7 R8 defaults
        s.cfg.fmt = fmt_ctrl_t'(RST_FMT_CTRL);
        // R9 R10 R11 R12 R13 R14 R15 defaults
        s.cfg.outc = out_ctrl_t'(RST_OUT_CTRL);
        // R16 R17 R18 R19 R20 defaults
        s.cfg.ifc = if_ctrl_t'(RST_IF_CTRL);
        // R21 zero output defaults
        s.cfg.zero = zero_ctrl_t'(RST_ZERO_CTRL);
        s.ramp = RAMP_NO_MUTE;
        s.left_level = RST_ATTEN;
        s.right_level = RST_ATTEN;
        return s;
    endfunction : reset_state

    function automatic logic [7:0] min8(input logic [7:0] a,
                                        input logic [7:0] b);
        return (a < b) ? a : b;
    endfunction : min8

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb begin
        logic multibit;
        logic muting;
        logic [2:0] step_limit;
        logic [7:0] rdv;
        multibit = 1'b0;
        muting = 1'b0;
        step_limit = 3'h0;
        rdv = READ_UNMAPPED;
        state_next = state_reg;
        state_next.rd_valid = 1'b0;
        state_next.soft_reset = 1'b0;
        state_next.zero_flags = i_ZERO_DETECT;
        state_next.link_device_number = i_LINK_DEVICE_NUMBER;

        multibit = !state_reg.cfg.ifc.one_bit_stream_mode &&
                   !state_reg.cfg.ifc.filter_bypass_sel;

        // R1 read access
        if (i_WORD_VALID && i_WORD.read_not_write) begin
            // R3 index decode
            unique case (i_WORD.index)
                IDX_LEFT_ATTEN: rdv = state_reg.left_atten_level;
                IDX_RIGHT_ATTEN: rdv = state_reg.right_atten_level;
                IDX_FMT_CTRL: rdv = state_reg.cfg.fmt;
                IDX_OUT_CTRL: rdv = state_reg.cfg.outc;
                IDX_IF_CTRL: rdv = state_reg.cfg.ifc;
                IDX_ZERO_CTRL: rdv = state_reg.cfg.zero;
                // R22 zero flags
                IDX_ZERO_STATUS: rdv = {6'h00, state_reg.zero_flags};
                // R23 link number
                IDX_LINK_ID: rdv = {3'h0, state_reg.link_device_number};
                default: rdv = READ_UNMAPPED;
            endcase
            state_next.rd_data = rdv;
            state_next.rd_valid = 1'b1;
        end

        // R1 write access
        if (i_WORD_VALID && !i_WORD.read_not_write) begin
            // R3 index decode
            unique case (i_WORD.index)
                IDX_LEFT_ATTEN: state_next.left_atten_level = i_WORD.data;
                IDX_RIGHT_ATTEN: state_next.right_atten_level = i_WORD.data;
                IDX_FMT_CTRL: state_next.cfg.fmt = fmt_ctrl_t'(i_WORD.data);
                IDX_OUT_CTRL: state_next.cfg.outc = out_ctrl_t'(i_WORD.data);
                IDX_IF_CTRL: begin
                    state_next.cfg.ifc = if_ctrl_t'(i_WORD.data);
                    // R27 reserved bit ignored
                    state_next.cfg.ifc.reserved_bit = 1'b0;
                    // R16 reset bit self-clears
                    state_next.cfg.ifc.software_system_reset = 1'b0;
                    state_next.soft_reset = i_WORD.data[6];
                end
                IDX_ZERO_CTRL: begin
                    state_next.cfg.zero = zero_ctrl_t'(i_WORD.data);
                    // R27 reserved bits ignored
                    state_next.cfg.zero.reserved_bit = 5'h00;
                end
                // R2 read-only registers
                default: begin
                end
            endcase
        end

        // R5 load gate
        // R25 hold without load
        if (state_reg.cfg.fmt.atten_load_enable && multibit) begin
            state_next.left_applied = state_reg.left_atten_level;
            state_next.right_applied = state_reg.right_atten_level;
        end

        // R8 multibit soft mute
        muting = state_reg.cfg.fmt.soft_mute_enable && multibit;
        // R10 step rate
        step_limit = 3'((4'h1 << state_reg.cfg.outc.atten_step_rate) - 4'h1);
        // R26 soft mute ramp
        if (i_SAMPLE_TICK) begin
            if (state_reg.step_cnt >= step_limit) begin
                state_next.step_cnt = 3'h0;
                if (muting && state_reg.ramp != RAMP_FULL_MUTE) begin
                    state_next.ramp = state_reg.ramp - 8'h01;
                end else if (!muting && state_reg.ramp != RAMP_NO_MUTE) begin
                    state_next.ramp = state_reg.ramp + 8'h01;
                end
            end else begin
                state_next.step_cnt = state_reg.step_cnt + 3'h1;
            end
        end

        state_next.left_level = min8(state_reg.left_applied, state_reg.ramp);
        state_next.right_level = min8(state_reg.right_applied, state_reg.ramp);
        // R24 infinite attenuation
        state_next.left_inf = state_reg.left_level <= ATTEN_MUTE_MAX;
        state_next.right_inf = state_reg.right_level <= ATTEN_MUTE_MAX;

        // R16 software reset
        if (state_reg.soft_reset) begin
            state_next = reset_state();
            state_next.zero_flags = i_ZERO_DETECT;
            state_next.link_device_number = i_LINK_DEVICE_NUMBER;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            state_reg <= reset_state();
        end else if (i_CE) begin
            state_reg <= state_next;
        end
    end

    assign o_RD_DATA = state_reg.rd_data;
    assign o_RD_VALID = state_reg.rd_valid;
    assign o_CONFIG = state_reg.cfg;
    assign o_SOFT_RESET = state_reg.soft_reset;
    assign o_LEFT_LEVEL = state_reg.left_level;
    assign o_RIGHT_LEVEL = state_reg.right_level;
    assign o_LEFT_INF_ATTEN = state_reg.left_inf;
    assign o_RIGHT_INF_ATTEN = state_reg.right_inf;

endmodule : mode_register_bank

`default_nettype wire

// ===== bench/mode_bank_sva.sv
`timescale 1ns/1ns
`default_nettype none
module mode_bank_sva (
    input wire logic I_CORE_CLK,
    input wire logic I_NRST,
    input wire logic i_CE,
    input wire logic i_WORD_VALID,
    input wire mode_bank_pkg::ctrl_word_t i_WORD,
    input wire logic [1:0] i_ZERO_DETECT,
    input wire logic [4:0] i_LINK_DEVICE_NUMBER,
    input wire logic [7:0] o_RD_DATA,
    input wire logic o_RD_VALID,
    input wire mode_bank_pkg::mode_cfg_t o_CONFIG,
    input wire logic o_SOFT_RESET,
    input wire logic [7:0] o_LEFT_LEVEL,
    input wire logic o_LEFT_INF_ATTEN
);
    import mode_bank_pkg::*;
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_NRST);
    // A word that lands while the bank resets itself is lost.
    sequence taken;
        i_CE && i_WORD_VALID && !o_SOFT_RESET;
    endsequence
    sequence rd_of(logic [6:0] idx);
        taken ##0 i_WORD.read_not_write && i_WORD.index == idx;
    endsequence
    sequence wr_of(logic [6:0] idx);
        taken ##0 !i_WORD.read_not_write && i_WORD.index == idx;
    endsequence
    AST_RD_ANSWER: assert property (
        taken ##0 i_WORD.read_not_write |=> o_RD_VALID)
        else $error("Read was not answered.");
    AST_RD_CAUSE: assert property (
        $rose(o_RD_VALID) |-> $past(i_WORD_VALID && i_WORD.read_not_write))
        else $error("Read answer without a read.");
    AST_WR_OUT: assert property (
        wr_of(IDX_OUT_CTRL) |=> o_CONFIG.outc == $past(i_WORD.data))
        else $error("Write did not land.");
    AST_SOFT_RESET: assert property (
        wr_of(IDX_IF_CTRL) ##0 i_WORD.data[6] |=> o_SOFT_RESET ##1
        (!o_SOFT_RESET && o_CONFIG == {RST_FMT_CTRL, RST_OUT_CTRL,
        RST_IF_CTRL, RST_ZERO_CTRL}))
        else $error("Software reset did not restore defaults.");
    AST_LINK_ID: assert property (
        rd_of(IDX_LINK_ID) |=>
        o_RD_DATA == {3'h0, $past(i_LINK_DEVICE_NUMBER, 2)})
        else $error("Wrong device number.");
    AST_ZERO_FLAGS: assert property (
        rd_of(IDX_ZERO_STATUS) |=>
        o_RD_DATA == {6'h00, $past(i_ZERO_DETECT, 2)})
        else $error("Wrong zero flags.");
    AST_UNMAPPED: assert property (
        taken ##0 i_WORD.read_not_write && (i_WORD.index < IDX_LEFT_ATTEN ||
        i_WORD.index > IDX_LINK_ID) |=> o_RD_DATA == READ_UNMAPPED)
        else $error("Unmapped read not zero.");
    AST_RSV_ZERO: assert property (
        o_CONFIG.zero.reserved_bit == 5'h00 && !o_CONFIG.ifc.reserved_bit)
        else $error("Reserved bit set.");
    AST_INF_FLAG: assert property (
        !$past(o_SOFT_RESET) |->
        o_LEFT_INF_ATTEN == ($past(o_LEFT_LEVEL) <= ATTEN_MUTE_MAX))
        else $error("Infinite attenuation flag wrong.");
endmodule : mode_bank_sva
bind mode_register_bank mode_bank_sva mode_bank_sva_i (.I_CORE_CLK,
    .I_NRST, .i_CE, .i_WORD_VALID, .i_WORD, .i_ZERO_DETECT,
    .i_LINK_DEVICE_NUMBER, .o_RD_DATA, .o_RD_VALID, .o_CONFIG,
    .o_SOFT_RESET, .o_LEFT_LEVEL, .o_LEFT_INF_ATTEN);
`default_nettype wire

// ===== bench/ctrl_host.sv
`timescale 1ns/1ns
`default_nettype none
module ctrl_host (
    input wire logic i_clk,
    output logic o_valid,
    output mode_bank_pkg::ctrl_word_t o_word
);
    import mode_bank_pkg::*;
    initial begin
        o_valid = 1'b0;
        o_word = 16'h0000;
    end
    task automatic send(input logic rd, input logic [6:0] idx,
                        input logic [7:0] data);
        @(negedge i_clk);
        o_valid = 1'b1;
        o_word = {rd, idx, data};
        @(negedge i_clk);
        o_valid = 1'b0;
        o_word = ~o_word;
    endtask : send
endmodule : ctrl_host
`default_nettype wire

// ===== bench/mode_register_bank_bench.sv
`timescale 1ns/1ns
`default_nettype none
module mode_register_bank_bench;
    import mode_bank_pkg::*;
    logic clk, nrst, ce, tick, w_valid, r_valid, s_rst, l_inf, r_inf;
    logic [1:0] zdet;
    logic [4:0] link;
    logic [7:0] r_data, l_lvl, r_lvl;
    ctrl_word_t word;
    mode_cfg_t cfg;
    int error_cnt = 0;
    int n_checks = 0;
    logic [7:0] rst_tab [6] = '{RST_ATTEN, RST_ATTEN, RST_FMT_CTRL,
        RST_OUT_CTRL, RST_IF_CTRL, RST_ZERO_CTRL};
    mode_register_bank mode_register_bank_i (.I_CORE_CLK(clk),
        .I_NRST(nrst), .i_CE(ce), .i_WORD_VALID(w_valid), .i_WORD(word),
        .i_SAMPLE_TICK(tick), .i_ZERO_DETECT(zdet),
        .i_LINK_DEVICE_NUMBER(link), .o_RD_DATA(r_data),
        .o_RD_VALID(r_valid), .o_CONFIG(cfg), .o_SOFT_RESET(s_rst),
        .o_LEFT_LEVEL(l_lvl), .o_RIGHT_LEVEL(r_lvl),
        .o_LEFT_INF_ATTEN(l_inf), .o_RIGHT_INF_ATTEN(r_inf));
    ctrl_host ctrl_host_i (.i_clk(clk), .o_valid(w_valid), .o_word(word));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        ctrl_host_i.send(1'b0, idx, d);
    endtask : wr
    task automatic rd(input logic [6:0] idx, input logic [7:0] exp);
        ctrl_host_i.send(1'b1, idx, 8'h00);
        chk({r_valid, r_data}, {1'b1, exp});
    endtask : rd
    task automatic end_sim();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // The whole sequence needs well under a thousand cycles.
    initial begin
        #1000000;
        error_cnt++;
        end_sim();
    end
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        tick = 1'b0;
        zdet = 2'h2;
        link = 5'h15;
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(IDX_LEFT_ATTEN + 7'(i), rst_tab[i]);
        end
        wr(IDX_OUT_CTRL, 8'hA5);
        rd(IDX_OUT_CTRL, 8'hA5);
        wr(IDX_IF_CTRL, 8'h8F);
        rd(IDX_IF_CTRL, 8'h0F);
        wr(IDX_ZERO_CTRL, 8'hFF);
        rd(IDX_ZERO_CTRL, 8'h07);
        wr(IDX_ZERO_STATUS, 8'hFF);
        rd(IDX_ZERO_STATUS, 8'h02);
        wr(IDX_LINK_ID, 8'hFF);
        rd(IDX_LINK_ID, 8'h15);
        rd(7'h0F, READ_UNMAPPED);
        rd(7'h20, READ_UNMAPPED);
        wr(IDX_LEFT_ATTEN, 8'h0F);
        wr(IDX_RIGHT_ATTEN, 8'h0E);
        repeat (4) @(negedge clk);
        chk({l_lvl, r_lvl}, {RST_ATTEN, RST_ATTEN});
        wr(IDX_FMT_CTRL, 8'hD0);
        repeat (4) @(negedge clk);
        chk({l_inf, l_lvl, r_inf, r_lvl}, 18'h0_1F0E);
        wr(IDX_LEFT_ATTEN, 8'hFF);
        wr(IDX_OUT_CTRL, 8'h20);
        wr(IDX_FMT_CTRL, 8'hD1);
        repeat (8) begin
            @(negedge clk);
            tick = 1'b1;
            @(negedge clk);
            tick = 1'b0;
        end
        repeat (2) @(negedge clk);
        chk(l_lvl, 8'hFB);
        ce = 1'b0;
        wr(IDX_OUT_CTRL, 8'h11);
        ce = 1'b1;
        rd(IDX_OUT_CTRL, 8'h20);
        wr(IDX_IF_CTRL, 8'h40);
        chk(s_rst, 1'b1);
        repeat (2) @(negedge clk);
        chk(cfg, {RST_FMT_CTRL, RST_OUT_CTRL, RST_IF_CTRL,
            RST_ZERO_CTRL});
        rd(IDX_IF_CTRL, RST_IF_CTRL);
        end_sim();
    end
endmodule : mode_register_bank_bench
`default_nettype wire
